// file: shared/serial_adapter_pkg.sv
// Purpose: Shared constants for the asynchronous serial adapter.
// Assumes: 40 MHz system clock; APB register access with 32-bit data.
// Notes:   Rate table holds tenths of baud; cycles per bit are rounded to nearest.
package serial_adapter_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ     = 40000000;
  localparam int DIV_W      = 20;
  localparam int RATE_COUNT = 16;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA   = 8'h00;
  localparam logic [7:0] ADDR_FORMAT = 8'h04;
  localparam logic [7:0] ADDR_RXRATE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_CTRL   = 8'h10;
  localparam logic [7:0] ADDR_MASK   = 8'h14;
  localparam logic [7:0] ADDR_PEND   = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Format register: [3:0] rate, [5:4] length-5, [6] two stop, [8:7] parity.
  localparam int FMT_RATE_LSB = 0;
  localparam int FMT_LEN_LSB  = 4;
  localparam int FMT_STOP_BIT = 6;
  localparam int FMT_PAR_LSB  = 7;
  // Status: [0] character available, [1] error, [2] transmitter busy.
  localparam int ST_AVAIL = 0;
  localparam int ST_ERR   = 1;
  localparam int ST_BUSY  = 2;
  // Control: [0] device clear (self clearing), [1] break, [2] irq enable, [3] fast alt.
  localparam int CT_CLEAR  = 0;
  localparam int CT_BREAK  = 1;
  localparam int CT_IRQEN  = 2;
  localparam int CT_FASTLO = 3;
  localparam int PEND_RX   = 0;

  localparam logic [8:0] FORMAT_RESET = 9'h030;
  localparam logic [7:0] MASK_RESET   = 8'h00;

  typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD, PAR_NONE2} parity_t;

  // Rates in tenths of baud so that 135.5 stays exact.
  localparam int RATE_DECI [RATE_COUNT] = '{192000, 96000, 72000, 48000, 36000, 24000,
    20000, 18000, 12000, 6000, 3000, 1500, 1355, 1100, 750, 500};
  localparam int ALT_DECI_HI = 500000;
  localparam int ALT_DECI_LO = 384000;

  function automatic logic [19:0] cycles_per_bit(input logic [3:0] sel, input logic fast);
    int deci;
    deci = RATE_DECI[sel];
    if (fast && sel == 4'hE) deci = ALT_DECI_HI;
    if (fast && sel == 4'hF) deci = ALT_DECI_LO;
    return 20'((64'(CLK_HZ) * 10 + deci / 2) / deci);
  endfunction : cycles_per_bit

endpackage : serial_adapter_pkg

// file: hdl/serial_receiver.sv
// Purpose: Start/stop framed character receiver.
// Assumes: rx_line synchronous to clk; format held steady during a frame.
// Notes:   Samples each bit at its centre counted from the start edge.
module serial_receiver
  import serial_adapter_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        rx_line,
  input  wire logic [19:0] bit_cycles,
  input  wire logic [1:0]  len_code,
  input  wire logic [1:0]  parity,
  output logic             done,
  output logic [7:0]       data,
  output logic             frame_err,
  output logic             par_err
);

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;
  rx_state_t   state_q;
  logic [19:0] cnt_q;
  logic [2:0]  idx_q;
  logic [7:0]  sh_q;
  logic        prev_q;
  logic        par_q;

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  // Half a bit after the falling edge the start bit is rechecked, so a glitch does not start a frame.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q   <= RX_IDLE;
      cnt_q     <= 20'h00000;
      idx_q     <= 3'h0;
      sh_q      <= 8'h00;
      prev_q    <= 1'b1;
      par_q     <= 1'b0;
      done      <= 1'b0;
      data      <= 8'h00;
      frame_err <= 1'b0;
      par_err   <= 1'b0;
    end else begin
      prev_q <= rx_line;
      done   <= 1'b0;
      if (cnt_q != 20'h00000) cnt_q <= cnt_q - 20'h00001;
      case (state_q)
        RX_IDLE: if (prev_q && !rx_line) begin
          state_q <= RX_START;
          cnt_q   <= bit_cycles >> 1;
        end
        RX_START: if (cnt_q == 20'h00000) begin
          if (rx_line) state_q <= RX_IDLE;
          else begin
            state_q <= RX_DATA;
            cnt_q   <= bit_cycles;
            idx_q   <= 3'h0;
            sh_q    <= 8'h00;
          end
        end
        RX_DATA: if (cnt_q == 20'h00000) begin
          sh_q[idx_q] <= rx_line;
          cnt_q       <= bit_cycles;
          idx_q       <= idx_q + 3'h1;
          if (idx_q == {1'b1, len_code}) state_q <= (parity == PAR_EVEN || parity == PAR_ODD) ? RX_PAR : RX_STOP;
        end
        RX_PAR: if (cnt_q == 20'h00000) begin
          par_q   <= rx_line;
          cnt_q   <= bit_cycles;
          state_q <= RX_STOP;
        end
        RX_STOP: if (cnt_q == 20'h00000) begin
          // Only the first stop bit is checked; done rises only now.
          done      <= 1'b1;
          data      <= sh_q;
          frame_err <= !rx_line;
          par_err   <= (parity == PAR_EVEN && (^sh_q ^ par_q)) ||
                       (parity == PAR_ODD && !(^sh_q ^ par_q));
          state_q   <= RX_IDLE;
        end
        default: state_q <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  done_at_stop_a: assert property (@(posedge clk) disable iff (!rstn)
    done |-> $past(state_q == RX_STOP)) else $error("receive done outside stop bit");
  frame_flag_a: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == RX_STOP && cnt_q == 20'h00000 && !rx_line) |=> frame_err)
    else $error("low stop bit not flagged");

endmodule : serial_receiver

// file: hdl/async_serial_adapter.sv
// Purpose: Asynchronous serial adapter with APB registers.
// Assumes: 40 MHz clk; APB slave with zero wait states.
// Notes:   A fast option swaps the two lowest rates for higher ones.
//
// How it works
// - Sixteen rate codes from 19,200 down to 50 baud, optional 50,000/38,400.
// - Bit period derived from clock, well within ten percent over twelve bits.
// - Transmit 5 to 8 data bits, one or two stop, none/even/odd parity.
// - Looped-back characters are received equal to those sent, any format.
// - Available flag sets after a looped-back character fully arrives.
// - Available flag rises only when reception of the whole character ends.
// - Available clears on bus reset, device clear, or reading the character.
// - A zero interrupt mask blocks the receive interrupt.
// - With interrupts enabled and a nonzero mask, request follows the available flag.
// - Pending status bit mirrors the receive interrupt request.
// - One combined error flag for parity, overrun and framing errors.
// - A character overwriting unread data sets the error flag.
// - A low stop bit sets the error flag.
// - A failed parity check sets the error flag.
// - Error flag clears on bus reset or device clear.
// - Format write loads both rates; receive-rate write changes receiver only.
// - A later format write returns receive rate to the transmit rate.
// - Frame is start, data, optional parity, then stop bits.
module async_serial_adapter
  import serial_adapter_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        rx_line,
  output logic             tx_line,
  output logic             rx_irq
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [8:0]  format_q;
  logic [3:0]  rx_rate_q;
  logic [7:0]  mask_q;
  logic        break_q;
  logic        irq_en_q;
  logic        fast_q;
  logic        avail_q;
  logic        err_q;
  logic [7:0]  rx_data_q;

  typedef enum {TX_IDLE, TX_SHIFT} tx_state_t;
  tx_state_t   tx_state_q;
  logic [11:0] tx_frame_q;
  logic [3:0]  tx_left_q;
  logic [19:0] tx_cnt_q;

  logic        rx_done;
  logic [7:0]  rx_byte;
  logic        rx_ferr;
  logic        rx_perr;

  logic        acc;
  logic        wr;
  logic        rd;
  logic        dev_clear;
  logic        data_read;
  logic        data_write;
  logic        irq_req;
  logic [19:0] tx_bit_cycles;
  logic [19:0] rx_bit_cycles;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Zero wait states keep the host loop simple; unmapped addresses raise pslverr.
  always_comb begin
    acc        = psel && penable;
    wr         = acc && pwrite;
    rd         = acc && !pwrite;
    dev_clear  = wr && paddr == ADDR_CTRL && pwdata[CT_CLEAR];
    data_read  = rd && paddr == ADDR_DATA;
    data_write = wr && paddr == ADDR_DATA;
  end
  assign pready = 1'b1;
  assign pslverr = acc && !(paddr inside {ADDR_DATA, ADDR_FORMAT, ADDR_RXRATE, ADDR_STATUS,
                                          ADDR_CTRL, ADDR_MASK, ADDR_PEND});

  // Read data comes straight from register state.
  always_comb begin
    prdata = 32'h00000000;
    case (paddr)
      ADDR_DATA:   prdata[7:0] = rx_data_q;
      ADDR_FORMAT: prdata[8:0] = format_q;
      ADDR_RXRATE: prdata[3:0] = rx_rate_q;
      ADDR_STATUS: begin
        prdata[ST_AVAIL] = avail_q;
        prdata[ST_ERR]   = err_q;
        prdata[ST_BUSY]  = tx_state_q != TX_IDLE;
      end
      ADDR_CTRL:   prdata[3:0] = {fast_q, irq_en_q, break_q, 1'b0};
      ADDR_MASK:   prdata[7:0] = mask_q;
      ADDR_PEND:   prdata[PEND_RX] = irq_req;
      default:     prdata = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // A format write reloads the receive rate as well, undoing any split rate.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      format_q  <= FORMAT_RESET;
      rx_rate_q <= FORMAT_RESET[3:0];
    end else if (wr && paddr == ADDR_FORMAT) begin
      format_q  <= pwdata[8:0];
      rx_rate_q <= pwdata[3:0];
    end else if (wr && paddr == ADDR_RXRATE) begin
      rx_rate_q <= pwdata[3:0];
    end
  end

  // Control and mask registers.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask_q   <= MASK_RESET;
      break_q  <= 1'b0;
      irq_en_q <= 1'b0;
      fast_q   <= 1'b0;
    end else begin
      if (wr && paddr == ADDR_MASK) mask_q <= pwdata[7:0];
      if (wr && paddr == ADDR_CTRL) begin
        break_q  <= pwdata[CT_BREAK];
        irq_en_q <= pwdata[CT_IRQEN];
        fast_q   <= pwdata[CT_FASTLO];
      end
    end
  end

  assign tx_bit_cycles = cycles_per_bit(format_q[3:0], fast_q);
  assign rx_bit_cycles = cycles_per_bit(rx_rate_q, fast_q);

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  // Frame is built whole on the write, shifted LSB first; writes while busy are dropped.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_state_q <= TX_IDLE;
      tx_frame_q <= 12'hFFF;
      tx_left_q  <= 4'h0;
      tx_cnt_q   <= 20'h00000;
    end else begin
      case (tx_state_q)
        TX_IDLE: if (data_write) begin
          logic [7:0] d;
          logic       pb;
          logic       has_par;
          logic [3:0] nd;
          d       = pwdata[7:0] & (8'hFF >> (2'h3 - format_q[5:4]));
          pb      = ^d ^ (format_q[8:7] == PAR_ODD);
          has_par = format_q[8:7] == PAR_EVEN || format_q[8:7] == PAR_ODD;
          nd      = 4'h5 + {2'h0, format_q[5:4]};
          tx_frame_q <= ({12'hFFF} << (nd + 4'h1)) | {3'h0, d, 1'b0};
          if (has_par) tx_frame_q[nd + 4'h1] <= pb;
          tx_left_q  <= nd + 4'h2 + {3'h0, has_par} + {3'h0, format_q[FMT_STOP_BIT]};
          tx_cnt_q   <= tx_bit_cycles;
          tx_state_q <= TX_SHIFT;
        end
        TX_SHIFT: begin
          if (tx_cnt_q > 20'h00001) tx_cnt_q <= tx_cnt_q - 20'h00001;
          else begin
            tx_cnt_q   <= tx_bit_cycles;
            tx_frame_q <= {1'b1, tx_frame_q[11:1]};
            tx_left_q  <= tx_left_q - 4'h1;
            if (tx_left_q == 4'h1) tx_state_q <= TX_IDLE;
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // Break forces the line low regardless of any frame in progress.
  assign tx_line = break_q ? 1'b0 : (tx_state_q == TX_SHIFT ? tx_frame_q[0] : 1'b1);

  // ----------------------------------------------------------------
  // Receiver and flags
  // ----------------------------------------------------------------
  serial_receiver u_rx (
    .clk        (clk),
    .rstn       (rstn),
    .rx_line    (rx_line),
    .bit_cycles (rx_bit_cycles),
    .len_code   (rx_len_code()),
    .parity     (format_q[8:7]),
    .done       (rx_done),
    .data       (rx_byte),
    .frame_err  (rx_ferr),
    .par_err    (rx_perr)
  );

  function automatic logic [1:0] rx_len_code();
    return format_q[5:4];
  endfunction : rx_len_code

  // Arrival wins over a clear in the same cycle, so no character is lost.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avail_q   <= 1'b0;
      rx_data_q <= 8'h00;
    end else if (rx_done) begin
      avail_q   <= 1'b1;
      rx_data_q <= rx_byte;
    end else if (dev_clear || data_read) begin
      avail_q   <= 1'b0;
    end
  end

  // The error flag compares against the flag as held before this arrival.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) err_q <= 1'b0;
    else if (rx_done && (avail_q || rx_ferr || rx_perr)) err_q <= 1'b1;
    else if (dev_clear) err_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  // Only the receive source exists; a zero mask blocks it.
  assign irq_req = irq_en_q && (mask_q != 8'h00) && avail_q;
  assign rx_irq  = irq_req;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  zero_mask_a: assert property (@(posedge clk) disable iff (!rstn)
    (mask_q == 8'h00) |-> !rx_irq) else $error("interrupt with zero mask");
  irq_follows_a: assert property (@(posedge clk) disable iff (!rstn)
    (irq_en_q && mask_q != 8'h00) |-> (rx_irq == avail_q)) else $error("irq not tracking flag");
  avail_set_a: assert property (@(posedge clk) disable iff (!rstn)
    rx_done |=> avail_q && rx_data_q == $past(rx_byte)) else $error("arrival not flagged");
  read_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    (data_read && !rx_done) |=> !avail_q) else $error("read did not clear");
  overrun_flag_a: assert property (@(posedge clk) disable iff (!rstn)
    (rx_done && avail_q) |=> err_q) else $error("overrun not flagged");
  clear_error_a: assert property (@(posedge clk) disable iff (!rstn)
    (dev_clear && !rx_done) |=> !err_q) else $error("error not cleared");
  format_rate_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr && paddr == ADDR_FORMAT) |=> rx_rate_q == format_q[3:0]) else $error("rates not rejoined");
  pend_mirror_a: assert property (@(posedge clk) disable iff (!rstn)
    (rd && paddr == ADDR_PEND) |-> prdata[PEND_RX] == rx_irq) else $error("pending bit wrong");
  tx_start_a: assert property (@(posedge clk) disable iff (!rstn)
    (tx_state_q == TX_IDLE && data_write && !break_q) |=> !tx_line) else $error("no start bit");

endmodule : async_serial_adapter

// file: testbench/loopback_plug.sv
// Purpose: Loopback plug model standing on the far side of the serial line.
// Assumes: Same clock as the adapter, so the returned line is synchronous.
// Notes:   The bench can invert the line to plant a bad bit; no other faults.
module loopback_plug (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic tx_line,
  input  wire logic corrupt,
  output logic      rx_line
);
  timeunit 1ns;
  timeprecision 100ps;

  // One flop of delay keeps the receive input free of combinational loops.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_line <= 1'b1;
    end else begin
      rx_line <= tx_line ^ corrupt;
    end
  end
endmodule : loopback_plug

// file: testbench/tb_async_serial_adapter.sv
// Purpose: Self-checking bench for the serial adapter through a loopback plug.
// Assumes: Fast option on, so the two highest codes give 50,000 and 38,400 baud, except in t_init.
// Notes:   Bits are sampled at nominal centres, so rate drift shows as bad bits.
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_async_serial_adapter
  import serial_adapter_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int CPB = 800; // Clocks per bit at 50,000 baud.
  logic        clk = 1'b0;
  logic        rstn, psel, penable, pwrite, pready, pslverr, slverr_seen;
  logic        rx_line, tx_line, rx_irq, corrupt;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  int          error_cnt = 0;
  int          total_checks = 0;

  // Free-running 40 MHz clock.
  always #12.5 clk = ~clk;

  async_serial_adapter dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .rx_line(rx_line), .tx_line(tx_line), .rx_irq(rx_irq));
  loopback_plug plug (.clk(clk), .rstn(rstn), .tx_line(tx_line), .corrupt(corrupt), .rx_line(rx_line));

  // ----------------------------------------------------------------
  // Bus and line helpers
  // ----------------------------------------------------------------
  // One APB transfer; read data is taken at the edge that sees pready.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    slverr_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // Polls one status bit; only the watchdog bounds a stuck flag.
  task automatic poll(input int b, input logic v);
    do apb(1'b0, ADDR_STATUS, 32'h0); while (r[b] !== v);
  endtask : poll

  // Checks a transmitted frame bit by bit at the nominal bit centres.
  task automatic obs(input int len, input int par, input int stops, input logic [7:0] d);
    logic [11:0] e;
    int          nb;
    e  = 12'hFFF;
    nb = 1 + len + int'(par != 0) + stops;
    e[0] = 1'b0;
    for (int i = 0; i < len; i++) e[1+i] = d[i];
    if (par != 0) e[1+len] = ^(d & 8'((1 << len) - 1)) ^ (par == 2);
    wait (tx_line === 1'b0);
    repeat (CPB / 2) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      `CHK(tx_line, e[i])
      repeat (CPB) @(posedge clk);
    end
  endtask : obs

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    apb(1'b0, ADDR_FORMAT, 32'h0);
    `CHK(r[8:0], FORMAT_RESET)
    apb(1'b0, ADDR_MASK, 32'h0);
    `CHK(r[7:0], MASK_RESET)
    apb(1'b0, ADDR_PEND, 32'h0);
    `CHK(r[0], 1'b0)
    apb(1'b0, 8'h1C, 32'h0);
    `CHK(slverr_seen, 1'b1)
  endtask : t_reset

  // Twelve-bit frame: 8 bits, even parity, two stops; flag stays low mid-frame.
  task automatic t_frame();
    apb(1'b1, ADDR_CTRL, 32'h8);
    apb(1'b1, ADDR_FORMAT, 32'h0FE);
    apb(1'b1, ADDR_DATA, 32'h55);
    fork
      obs(8, 1, 2, 8'h55);
      begin
        repeat (3 * CPB) @(posedge clk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK(r[0], 1'b0)
      end
    join
    poll(ST_AVAIL, 1'b1);
    apb(1'b0, ADDR_DATA, 32'h0); // Read before the next character lands.
    `CHK(r[7:0], 8'h55)
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(r[1:0], 2'b00)
  endtask : t_frame

  // Five bits, odd parity; the mask gates the request and its pending bit.
  task automatic t_irq();
    apb(1'b1, ADDR_FORMAT, 32'h10E);
    apb(1'b1, ADDR_DATA, 32'h1B);
    obs(5, 2, 1, 8'h1B);
    poll(ST_AVAIL, 1'b1);
    apb(1'b1, ADDR_CTRL, 32'hC);
    apb(1'b1, ADDR_MASK, 32'h0);
    `CHK(rx_irq, 1'b0)
    apb(1'b0, ADDR_PEND, 32'h0);
    `CHK(r[0], 1'b0)
    apb(1'b1, ADDR_MASK, 32'hFF);
    `CHK(rx_irq, 1'b1)
    apb(1'b0, ADDR_PEND, 32'h0);
    `CHK(r[0], 1'b1)
    apb(1'b0, ADDR_DATA, 32'h0);
    `CHK(r[4:0], 5'h1B)
    `CHK(rx_irq, 1'b0)
  endtask : t_irq

  // Two characters with no read in between, then a device clear.
  task automatic t_overrun();
    apb(1'b1, ADDR_DATA, 32'h0A);
    poll(ST_BUSY, 1'b0);
    apb(1'b1, ADDR_DATA, 32'h15);
    poll(ST_BUSY, 1'b0);
    repeat (CPB) @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(r[1:0], 2'b11)
    `CHK(rx_irq, 1'b1)
    apb(1'b1, ADDR_CTRL, 32'hD);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(r[1:0], 2'b00)
  endtask : t_overrun

  // A held break looks like a frame whose stop bit is low.
  task automatic t_break();
    apb(1'b1, ADDR_CTRL, 32'hE);
    repeat (9 * CPB) @(posedge clk);
    apb(1'b1, ADDR_CTRL, 32'hC);
    repeat (9 * CPB) @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(r[1], 1'b1)
    apb(1'b1, ADDR_CTRL, 32'hD);
  endtask : t_break

  // A line held low gives a bad-stop character; a bus-wide reset then wipes both flags.
  task automatic t_init();
    corrupt <= 1'b1;
    repeat (8 * CPB) @(posedge clk);
    corrupt <= 1'b0;
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(r[1:0], 2'b11)
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(r[1:0], 2'b00)
    `CHK(rx_irq, 1'b0)
    // With the fast option off, code F is 50 baud, so the start bit outlasts two short bits.
    apb(1'b1, ADDR_FORMAT, 32'h10F);
    apb(1'b1, ADDR_DATA, 32'h01);
    repeat (2 * CPB) @(posedge clk);
    `CHK(tx_line, 1'b0)
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    `CHK(tx_line, 1'b1)
    apb(1'b1, ADDR_CTRL, 32'h8);
    apb(1'b1, ADDR_FORMAT, 32'h10E);
  endtask : t_init

  // The plug inverts data bit 0, so the odd parity check must fail.
  task automatic t_parity();
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(r[1:0], 2'b00)
    apb(1'b1, ADDR_DATA, 32'h00);
    wait (tx_line === 1'b0);
    repeat (CPB) @(posedge clk);
    corrupt <= 1'b1;
    repeat (CPB) @(posedge clk);
    corrupt <= 1'b0;
    poll(ST_BUSY, 1'b0);
    repeat (CPB) @(posedge clk);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK(r[1:0], 2'b11)
    apb(1'b0, ADDR_DATA, 32'h0);
    `CHK(r[4:0], 5'h01)
    apb(1'b1, ADDR_CTRL, 32'h9);
  endtask : t_parity

  // A slower receiver reads a zero as C0; a later format write realigns it.
  // The first format uses parity code 3, which must behave as no parity.
  task automatic t_rates();
    apb(1'b1, ADDR_FORMAT, 32'h1BE);
    apb(1'b1, ADDR_RXRATE, 32'hF);
    apb(1'b1, ADDR_DATA, 32'h00);
    poll(ST_AVAIL, 1'b1);
    apb(1'b0, ADDR_DATA, 32'h0);
    `CHK(r[7:0], 8'hC0)
    apb(1'b1, ADDR_FORMAT, 32'h03E);
    apb(1'b1, ADDR_DATA, 32'h00);
    poll(ST_AVAIL, 1'b1);
    apb(1'b0, ADDR_DATA, 32'h0);
    `CHK(r[7:0], 8'h00)
  endtask : t_rates

  // ----------------------------------------------------------------
  // Verdict, main sequence and watchdog
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  // Reset for eight cycles, then the scenarios in order.
  initial begin
    rstn    = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    corrupt = 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_frame();
    t_irq();
    t_overrun();
    t_break();
    t_init();
    t_parity();
    t_rates();
    summarize();
  end

  // The scenarios need about 80,000 cycles; the margin covers slow flags.
  initial begin
    repeat (95000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule : tb_async_serial_adapter
